// ---- core/vwk_pkg.sv ----
// Constants shared by the interrupt request and wake-up logic.
package vwk_pkg;
	localparam int NUM_FLAGS = 5;
	localparam int F_SER = 0;
	localparam int F_NV = 1;
	localparam int F_TMA = 2;
	localparam int F_TMP = 3;
	localparam int F_GRP = 4;
	localparam int VEC_W = 12;
	localparam logic [VEC_W-1:0] VEC_GRP = 12'h00c;
	localparam logic [VEC_W-1:0] VEC_SER = 12'h010;
	localparam logic [VEC_W-1:0] VEC_NV = 12'h014;
	localparam logic [VEC_W-1:0] VEC_RST = 12'h000;
	localparam logic GIE_RST = 1'b0;
	localparam logic FLAG_RST = 1'b0;
endpackage : vwk_pkg

// ---- core/vwk_flag.sv ----
// One interrupt request flag: hardware set wins over any clear.
`timescale 1ns/100ps
module vwk_flag
	import vwk_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic set,
	input wire logic clr,
	input wire logic svc,
	output logic flag
);
	wire next_flag;

	// A flag holds through a cleared enable; only service or software drops it.
	assign next_flag = set | (flag & ~clr & ~svc);

	always_ff @(posedge clk) begin
		if (srst) begin
			flag <= FLAG_RST;
		end else begin
			flag <= next_flag;
		end
	end
endmodule : vwk_flag

// ---- core/vwk_ctrl.sv ----
// Interrupt request gating, vectoring, global enable and wake-up logic.
`timescale 1ns/100ps
module vwk_ctrl
	import vwk_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic ser_byte_done,
	input wire logic ser_addr_match,
	input wire logic ser_bus_timeout,
	input wire logic nv_write_done,
	input wire logic timer_match_a,
	input wire logic timer_match_p,
	input wire logic serial_if_int_en,
	input wire logic nv_write_int_en,
	input wire logic timer_a_int_en,
	input wire logic timer_p_int_en,
	input wire logic grouped_int_en,
	input wire logic [NUM_FLAGS-1:0] flag_set,
	input wire logic [NUM_FLAGS-1:0] flag_clr,
	input wire logic gie_set,
	input wire logic gie_clr,
	input wire logic return_with_enable_instr,
	input wire logic stack_full,
	input wire logic low_power,
	output logic [NUM_FLAGS-1:0] req_flag,
	output logic global_int_en,
	output logic int_call,
	output logic [VEC_W-1:0] int_vector,
	output logic wake
);
	////////////////////////////////////////////////////////////////////////////
	wire [NUM_FLAGS-1:0] set_ev;
	wire [NUM_FLAGS-1:0] svc;
	wire [NUM_FLAGS-1:0] rise;
	wire req_ser;
	wire req_nv;
	wire req_grp;
	wire take;
	wire sel_grp;
	wire sel_ser;
	wire sel_nv;
	wire [VEC_W-1:0] next_vector;
	wire next_gie;
	logic [NUM_FLAGS-1:0] flag_prev;

	assign set_ev[F_SER] = ser_byte_done | ser_addr_match | ser_bus_timeout
		| flag_set[F_SER];
	assign set_ev[F_NV] = nv_write_done | flag_set[F_NV];
	assign set_ev[F_TMA] = timer_match_a | flag_set[F_TMA];
	assign set_ev[F_TMP] = timer_match_p | flag_set[F_TMP];
	// The grouped flag follows any member setting its own flag.
	assign set_ev[F_GRP] = set_ev[F_TMA] | set_ev[F_TMP] | flag_set[F_GRP];

	genvar gi;
	generate
		for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_flag
			vwk_flag u_flag (
				.clk(clk),
				.srst(srst),
				.set(set_ev[gi]),
				.clr(flag_clr[gi]),
				.svc(svc[gi]),
				.flag(req_flag[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	assign req_ser = req_flag[F_SER] & serial_if_int_en;
	assign req_nv = req_flag[F_NV] & nv_write_int_en;
	assign req_grp = req_flag[F_GRP] & grouped_int_en
		& ((req_flag[F_TMA] & timer_a_int_en) | (req_flag[F_TMP] & timer_p_int_en));

	// A full stack holds the request pending rather than overrunning it.
	assign take = global_int_en & ~stack_full & (req_ser | req_nv | req_grp);

	// Fixed priority, lowest vector first.
	assign sel_grp = req_grp;
	assign sel_ser = req_ser & ~req_grp;
	assign sel_nv = req_nv & ~req_grp & ~req_ser;
	assign next_vector = sel_grp ? VEC_GRP : (sel_ser ? VEC_SER : VEC_NV);

	assign svc[F_SER] = take & sel_ser;
	assign svc[F_NV] = take & sel_nv;
	// Timer source flags stay set; software must clear them itself.
	assign svc[F_TMA] = 1'b0;
	assign svc[F_TMP] = 1'b0;
	assign svc[F_GRP] = take & sel_grp;

	// A call drops the global enable so that it cannot fire twice.
	assign next_gie = take ? 1'b0 :
		((return_with_enable_instr | gie_set) ? 1'b1 : (gie_clr ? 1'b0 : global_int_en));

	always_ff @(posedge clk) begin
		if (srst) begin
			global_int_en <= GIE_RST;
		end else begin
			global_int_en <= next_gie;
		end
	end

	// The call pulse asks the core to push the program counter and nothing else.
	always_ff @(posedge clk) begin
		if (srst) begin
			int_call <= 1'b0;
			int_vector <= VEC_RST;
		end else begin
			int_call <= take;
			int_vector <= take ? next_vector : int_vector;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Only a low-to-high change wakes; enables play no part, so a flag that
	// software raised before sleeping stays silent.
	assign rise = req_flag & ~flag_prev;

	always_ff @(posedge clk) begin
		if (srst) begin
			flag_prev <= {NUM_FLAGS{FLAG_RST}};
			wake <= 1'b0;
		end else begin
			flag_prev <= req_flag;
			wake <= low_power & (|rise);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	sequence s_nv_taken;
		int_call && int_vector == VEC_NV;
	endsequence

	sequence s_grp_taken;
		int_call && int_vector == VEC_GRP;
	endsequence

	sequence s_ser_taken;
		int_call && int_vector == VEC_SER;
	endsequence

	ser_flag_set_a: assert property (ser_bus_timeout |=> req_flag[F_SER])
		else $error("serial flag not set by timeout");
	ser_gate_a: assert property (s_ser_taken
		|-> $past(global_int_en) && $past(serial_if_int_en))
		else $error("serial call without enables");
	call_gie_a: assert property (int_call |-> !global_int_en)
		else $error("global enable still set after call");
	nv_flag_set_a: assert property (nv_write_done |=> req_flag[F_NV])
		else $error("nonvolatile flag not set");
	nv_gate_a: assert property (s_nv_taken |-> $past(nv_write_int_en))
		else $error("nonvolatile call without enable");
	nv_clear_a: assert property (s_nv_taken and !$past(set_ev[F_NV])
		|-> !req_flag[F_NV])
		else $error("nonvolatile flag not cleared on service");
	timer_group_a: assert property (timer_match_p
		|=> req_flag[F_TMP] && req_flag[F_GRP])
		else $error("timer match did not set flags");
	grp_gate_a: assert property (s_grp_taken |-> $past(grouped_int_en))
		else $error("grouped call without enable");
	timer_keep_a: assert property (s_grp_taken
		|-> req_flag[F_TMA] || req_flag[F_TMP])
		else $error("timer flags cleared by service");
	wake_rise_a: assert property (!req_flag[F_NV] ##1 req_flag[F_NV] && low_power
		|=> wake)
		else $error("no wake on flag rise");
	wake_quiet_a: assert property (wake |-> $past(low_power) && $past(|rise))
		else $error("wake without a flag rise");
	flag_hold_a: assert property (req_flag[F_SER] && !flag_clr[F_SER] && !svc[F_SER]
		|=> req_flag[F_SER])
		else $error("flag dropped without clear");
	stack_block_a: assert property (int_call |-> !$past(stack_full))
		else $error("call taken with full stack");
	call_single_a: assert property (int_call |=> !int_call)
		else $error("call pulse longer than one cycle");
	ret_enable_a: assert property (return_with_enable_instr && !take |=> global_int_en)
		else $error("return did not enable interrupts");
	prio_order_a: assert property (int_call && $past(req_grp) |-> int_vector == VEC_GRP)
		else $error("priority order broken");
	grp_follow_a: assert property (timer_match_a |=> req_flag[F_GRP])
		else $error("grouped flag did not follow member");

	////////////////////////////////////////////////////////////////////////////
	// Service, priority and enable checks. A call is registered one edge after
	// the take decision, so these look back one cycle for the cause.
	// The service clears are checked only when no new set lands in the same
	// cycle, since a fresh set must win over the automatic clear.

	ser_clear_a: assert property (s_ser_taken and !$past(set_ev[F_SER])
		|-> !req_flag[F_SER])
		else $error("serial flag not cleared on service");
	grp_clear_a: assert property (s_grp_taken and !$past(set_ev[F_GRP])
		|-> !req_flag[F_GRP])
		else $error("grouped flag not cleared on service");
	call_gated_a: assert property (int_call
		|-> $past(global_int_en))
		else $error("call taken with global enable low");
	grp_source_a: assert property (s_grp_taken
		|-> $past(req_flag[F_TMA] && timer_a_int_en) || $past(req_flag[F_TMP] && timer_p_int_en))
		else $error("grouped call without an enabled timer source");
	nv_prio_a: assert property (s_nv_taken
		|-> !$past(req_ser) && !$past(req_grp))
		else $error("nonvolatile call ahead of a higher priority");
	ser_prio_a: assert property (s_ser_taken
		|-> !$past(req_grp))
		else $error("serial call ahead of grouped call");

	// A full stack must hold every request back, however many are pending.
	stack_wait_a: assert property (stack_full
		|=> !int_call)
		else $error("call issued while stack full");
	vec_hold_a: assert property (!int_call
		|-> $stable(int_vector))
		else $error("vector changed without a call");
	gie_hold_a: assert property (!global_int_en && !return_with_enable_instr && !gie_set
		|=> !global_int_en)
		else $error("global enable rose without a set");
	set_wins_a: assert property (set_ev[F_NV]
		|=> req_flag[F_NV])
		else $error("flag set lost");
	wake_lp_a: assert property (!low_power
		|=> !wake)
		else $error("wake outside low power");
endmodule : vwk_ctrl

// ---- bench/vwk_core_model.sv ----
// Behavioural model of the core sequencer and its return stack.
`timescale 1ns/100ps
module vwk_core_model #(
	parameter int DEPTH = 2
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic int_call,
	input wire logic ret_en,
	input wire logic ret_plain,
	output logic stack_full,
	output logic return_with_enable_instr
);
	logic [3:0] depth;
	assign stack_full = (depth == 4'(DEPTH));
	assign return_with_enable_instr = ret_en;
	// Only the return address is stacked and routines never call deeper.
	always_ff @(posedge clk) begin
		if (srst)
			depth <= 4'h0;
		else if (int_call)
			depth <= depth + 4'h1;
		else if (ret_en || ret_plain)
			depth <= depth - 4'h1;
	end
endmodule : vwk_core_model

// ---- bench/vwk_ctrl_test.sv ----
// Self-checking bench for the interrupt request and wake-up logic.
`timescale 1ns/100ps
module vwk_ctrl_test;
	import vwk_pkg::*;
	logic clk = 1'b0, srst = 1'b1, lp = 1'b0, gs = 1'b0, gc = 1'b0, re = 1'b0, rp = 1'b0;
	logic [5:0] ev = 6'h00;
	logic [4:0] en = 5'h00, fs = 5'h00, fc = 5'h00;
	logic [NUM_FLAGS-1:0] rf;
	logic gie, call, wake, full, rwe;
	logic [VEC_W-1:0] vec;
	logic [VEC_W-1:0] exp_q[$];
	logic [11:0] after_svc[3] = '{12'h00f, 12'h00e, 12'h00c};
	int failures = 0, n_compared = 0;
	vwk_ctrl DUT (.clk(clk), .srst(srst), .ser_byte_done(ev[0]), .ser_addr_match(ev[1]),
		.ser_bus_timeout(ev[2]), .nv_write_done(ev[3]),
		.timer_match_a(ev[4]), .timer_match_p(ev[5]),
		.serial_if_int_en(en[0]), .nv_write_int_en(en[1]), .timer_a_int_en(en[2]),
		.timer_p_int_en(en[3]), .grouped_int_en(en[4]), .flag_set(fs), .flag_clr(fc),
		.gie_set(gs), .gie_clr(gc), .return_with_enable_instr(rwe), .stack_full(full),
		.low_power(lp), .req_flag(rf), .global_int_en(gie), .int_call(call),
		.int_vector(vec), .wake(wake));
	vwk_core_model #(.DEPTH(2)) core (.clk(clk), .srst(srst), .int_call(call), .ret_en(re),
		.ret_plain(rp), .stack_full(full), .return_with_enable_instr(rwe));
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		forever #4 clk = ~clk;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic test_done();
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : test_done
	task automatic hit(input logic [5:0] m);
		tick(1); ev <= m; tick(1); ev <= 6'h00; @(negedge clk);
	endtask : hit
	task automatic wk(input logic [11:0] exp);
		tick(1); @(negedge clk); chk(12'(wake), exp);
	endtask : wk
	// A hang in the call sequence is cut short here and counted.
	task automatic drain();
		int i;
		for (i = 0; i < 40 && exp_q.size() != 0; i++) tick(1);
		if (exp_q.size() != 0) begin
			failures++;
			test_done();
		end
	endtask : drain
	// Each call is matched against the oldest expected vector.
	always @(negedge clk) begin
		if (call === 1'b1 && exp_q.size() == 0) chk(12'(call), 12'h000);
		else if (call === 1'b1) chk(vec, exp_q.pop_front());
	end
	initial begin
		void'($urandom(32'h7a3afbf2));
		tick(5); srst <= 1'b0;
		@(negedge clk); chk(12'({rf, gie, call, wake}), 12'h000);
		for (int k = 0; k < 3; k++) begin
			hit(6'(1 << k)); chk(12'(rf), 12'h001);
			tick(1); fc <= 5'h01; tick(1); fc <= 5'h00;
		end
		lp <= 1'b1;
		hit(6'h08); chk(12'(rf), 12'h002);
		wk(12'h001);
		hit(6'h10); chk(12'(rf), 12'h016);
		wk(12'h001);
		// Software suppresses a wake-up by leaving the flag high.
		hit(6'h08); wk(12'h000);
		hit(6'h20); wk(12'h001);
		tick(1); lp <= 1'b0;
		hit(6'h01); tick(4); @(negedge clk); chk(12'(rf), 12'h01f);
		tick(1); en <= 5'h1f;
		exp_q = '{VEC_GRP, VEC_SER, VEC_NV};
		for (int k = 0; k < 3; k++) begin
			tick(1); {gs, re} <= (k == 0) ? 2'h2 : 2'h1; tick(1); {gs, re} <= 2'h0;
			tick(2); @(negedge clk); chk(12'({gie, rf}), after_svc[k]);
		end
		drain();
		tick(1); rp <= 1'b1; tick(1); rp <= 1'b0;
		tick(2); @(negedge clk); chk(12'(gie), 12'h000);
		tick(1); fs <= 5'h03; en <= {3'($urandom), 2'b00}; tick(1); fs <= 5'h00;
		tick(1); gs <= 1'b1; tick(1); gs <= 1'b0; tick(3);
		@(negedge clk); chk(12'({gie, rf}), 12'h02f);
		// Software clear of the global enable, then set it again for the calls.
		tick(1); gc <= 1'b1; tick(1); gc <= 1'b0; tick(1);
		@(negedge clk); chk(12'(gie), 12'h000);
		tick(1); gs <= 1'b1; tick(1); gs <= 1'b0;
		tick(1); exp_q = '{VEC_SER, VEC_NV}; en <= 5'h03; tick(3);
		tick(1); gs <= 1'b1; tick(1); gs <= 1'b0; drain();
		tick(1); fs <= 5'h01; gs <= 1'b1; tick(1); fs <= 5'h00; gs <= 1'b0; tick(4);
		@(negedge clk); chk(12'({gie, full, rf}), 12'h06d);
		exp_q.push_back(VEC_SER); tick(1); rp <= 1'b1; tick(1); rp <= 1'b0; drain();
		test_done();
	end
endmodule : vwk_ctrl_test
